//--- verilog/mfp_pkg.sv
// Purpose: Shared constants and types for the multifunction pin select block
// Assumes: 100 MHz CLK, classic Wishbone with 32-bit data
// Notes: Sequence registers sit at four times their index
package mfp_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NUM_PINS = 4;
  localparam int SEQ_DEPTH = 10;
  localparam int EE_AW = 12;
  localparam logic [3:0] SEQ_LAST = 4'h9;
  localparam logic [13:0] END_INDEX = 14'h0e3c;
  localparam logic [13:0] SPARE_INDEX = 14'h0e3d;
  localparam logic [13:0] SPARE_TOP_INDEX = 14'h0e45;
  localparam logic [15:0] END_ADDR = {END_INDEX, 2'b00};
  localparam logic [15:0] SPARE_TOP_ADDR = {SPARE_TOP_INDEX, 2'b00};
  localparam logic [15:0] PIN_CODE_ADDR = 16'h0000;
  localparam logic [15:0] PIN_CODE_TOP = 16'h000c;
  localparam logic [15:0] SEQ_CTRL_ADDR = 16'h0010;
  localparam logic [15:0] PIN_LEVEL_ADDR = 16'h0014;
  localparam int SEQ_START_BIT = 0;
  localparam int SEQ_BUSY_BIT = 0;
  localparam int SEQ_PTR_LSB = 16;
  localparam logic [7:0] END_CODE = 8'hff;
  localparam logic [7:0] PAUSE_CODE = 8'hfe;
  localparam logic [7:0] END_RESET = 8'hff;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [7:0] PIN_CODE_RESET = 8'h00;
  localparam int DIR_BIT = 7;
  localparam int DIV_W = 5;
  // Output codes
  localparam logic [7:0] OUT_HIGH = 8'h81;
  localparam logic [7:0] OUT_DIV = 8'h82;
  localparam logic [7:0] OUT_WDOG = 8'h83;
  localparam logic [7:0] OUT_EE = 8'h84;
  localparam logic [7:0] OUT_PLL = 8'h87;
  localparam logic [7:0] OUT_PLL_TOP = 8'h8d;
  localparam logic [7:0] OUT_DL = 8'h90;
  localparam logic [7:0] OUT_DL_TOP = 8'h96;
  localparam logic [7:0] OUT_CLAMP = 8'h97;
  localparam logic [7:0] OUT_HAVAIL = 8'h98;
  localparam logic [7:0] OUT_HUPD = 8'h99;
  localparam logic [7:0] OUT_AFAULT = 8'ha0;
  localparam logic [7:0] OUT_BFAULT = 8'ha1;
  localparam logic [7:0] OUT_AVALID = 8'hb0;
  localparam logic [7:0] OUT_BVALID = 8'hb1;
  localparam logic [7:0] OUT_AACT = 8'hc0;
  localparam logic [7:0] OUT_BACT = 8'hc1;
  localparam logic [7:0] OUT_SYNC = 8'hd0;
  localparam logic [7:0] OUT_SOFT = 8'hd1;
  // Input codes
  localparam logic [7:0] IN_IOUPD = 8'h01;
  localparam logic [7:0] IN_PDOWN = 8'h02;
  localparam logic [7:0] IN_WDCLR = 8'h03;
  localparam logic [7:0] IN_IRQCLR = 8'h04;
  localparam logic [7:0] IN_HRST = 8'h05;
  localparam logic [7:0] IN_HOLD = 8'h10;
  localparam logic [7:0] IN_FREE = 8'h11;
  localparam logic [7:0] IN_PRST = 8'h12;
  localparam logic [7:0] IN_PINC = 8'h13;
  localparam logic [7:0] IN_PDEC = 8'h14;
  localparam logic [7:0] IN_OVRA = 8'h20;
  localparam logic [7:0] IN_OVRB = 8'h21;
  localparam logic [7:0] IN_VTOA = 8'h30;
  localparam logic [7:0] IN_VTOB = 8'h31;
  localparam logic [7:0] IN_EN0 = 8'h40;
  localparam logic [7:0] IN_EN1 = 8'h41;
  localparam logic [7:0] IN_ENB = 8'h46;
  localparam logic [7:0] IN_SYNC = 8'h47;
  localparam int DL_PHASE = 4;
  typedef struct packed {
    logic [2:0] ee;
    logic [4:0] pll;
    logic analog_loop_lock;
    logic [6:0] dl_state;
    logic dl_clamped;
    logic hist_avail;
    logic hist_updated;
    logic ref_a_fault;
    logic ref_b_fault;
    logic ref_a_valid;
    logic ref_b_valid;
    logic ref_b_active;
    logic sync_pulse;
    logic soft_cfg;
  } status_type;
  typedef struct packed {
    logic io_update;
    logic power_down;
    logic wd_clear;
    logic clear_irqs;
    logic hist_reset;
    logic user_holdover;
    logic user_freerun;
    logic phase_reset;
    logic phase_inc;
    logic phase_dec;
    logic override_a;
    logic override_b;
    logic force_to_a;
    logic force_to_b;
    logic clock_output_zero_enable;
    logic clock_output_one_enable;
    logic sync_outputs;
  } control_type;
  typedef struct packed {
    logic valid;
    logic [EE_AW-1:0] addr;
    logic [7:0] data;
  } ee_write_type;
  typedef enum {SEQ_IDLE, SEQ_RUN} seq_state_type;
endpackage

//--- verilog/multifunction_pin_select.sv
// Purpose: Function select for multifunction pins and sequence end handling
// Assumes: Status and watchdog come from logic on CLK; pins are asynchronous
// Notes: Wishbone answers one cycle after a request is seen

// Overview of operation
// - End code is stored, EEPROM pointer returns to zero, sequencer goes idle
// - Pause code is stored, pointer advances, sequencer goes idle
// - Area after end location holds further instructions run in order
// - Code bit 7 high makes the pin an output chosen by the code
// - Code bit 7 low makes the pin an input driving a control action
// - Codes 0x80 to 0x83: low, high, clock over 32, watchdog
// - Codes 0x84 to 0x86 mirror EEPROM upload, download and fault
// - Codes 0x87 to 0x8d mirror PLL status bits 0 to 6
// - 0x8c is all three locks; 0x8d is loop phase and analog lock
// - Codes 0x90 to 0x96 mirror the digital loop state bits
// - 0x97 clamped, 0x98 history available, 0x99 history updated
// - 0xa0/0xa1 reference faults, 0xb0/0xb1 reference valid flags
// - 0xc0/0xc1 show reference A or B active from one bit
// - 0xd0 distribution sync pulse, 0xd1 soft pin configuration busy
// - 0x00 no function, 0x01 I/O update, 0x02 full power-down
// - 0x03 to 0x05 watchdog clear, clear interrupts, history reset
// - 0x10 user holdover, 0x11 user free run
// - 0x12 to 0x14 reset, increment, decrement phase offset
// - 0x20/0x21 monitor override, 0x30/0x31 forced validation timeout
// - 0x40 enables output zero, 0x41 output one, 0x46 both
// - 0x47 synchronizes the clock distribution outputs
module multifunction_pin_select
  import mfp_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [15:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Multifunction pins
  input wire logic [NUM_PINS-1:0] PIN_I,
  output logic [NUM_PINS-1:0] PIN_O,
  output logic [NUM_PINS-1:0] PIN_OE_N,
  // Device side
  input wire status_type STATUS,
  input wire logic WATCHDOG,
  output control_type CTRL,
  output ee_write_type EE
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] pin_code [NUM_PINS];
  logic [7:0] seq_mem [SEQ_DEPTH];
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [NUM_PINS-1:0] sync3;
  logic [NUM_PINS-1:0] pin_level;
  logic [DIV_W-1:0] div_count;
  control_type pin_act [NUM_PINS];
  control_type next_ctrl;
  seq_state_type seq_state;
  logic [3:0] scan;
  logic [EE_AW-1:0] ee_ptr;
  logic [7:0] instr;
  logic req;
  logic wr;
  logic [3:0] seq_idx;
  logic seq_hit;
  logic [1:0] pin_idx;
  logic pin_hit;

  // Request seen once; ack drops the cycle after it rose
  assign req = CYC_I & STB_I & ~ACK_O;
  assign wr = req & WE_I & SEL_I[0];
  assign seq_hit = (ADR_I >= END_ADDR) && (ADR_I <= SPARE_TOP_ADDR)
                   && (ADR_I[1:0] == 2'b00);
  assign seq_idx = 4'(ADR_I[15:2] - END_INDEX);
  assign pin_hit = (ADR_I >= PIN_CODE_ADDR) && (ADR_I <= PIN_CODE_TOP)
                   && (ADR_I[1:0] == 2'b00);
  assign pin_idx = ADR_I[3:2];
  assign instr = seq_mem[scan];

  function automatic logic out_level(input logic [7:0] code,
                                     input status_type st,
                                     input logic div,
                                     input logic wd);
    logic [6:0] pll;
    logic r;
    pll = {st.dl_state[DL_PHASE] & st.analog_loop_lock,
           st.dl_state[DL_PHASE] & st.analog_loop_lock & st.pll[0],
           st.pll[4:0]};
    r = 1'b0;
    if (code == OUT_HIGH) begin
      r = 1'b1;
    end else if (code == OUT_DIV) begin
      r = div;
    end else if (code == OUT_WDOG) begin
      r = wd;
    end else if (code >= OUT_EE && code < OUT_PLL) begin
      r = st.ee[2'(code - OUT_EE)];
    end else if (code >= OUT_PLL && code <= OUT_PLL_TOP) begin
      r = pll[3'(code - OUT_PLL)];
    end else if (code >= OUT_DL && code <= OUT_DL_TOP) begin
      r = st.dl_state[3'(code - OUT_DL)];
    end else if (code == OUT_CLAMP) begin
      r = st.dl_clamped;
    end else if (code == OUT_HAVAIL) begin
      r = st.hist_avail;
    end else if (code == OUT_HUPD) begin
      r = st.hist_updated;
    end else if (code == OUT_AFAULT) begin
      r = st.ref_a_fault;
    end else if (code == OUT_BFAULT) begin
      r = st.ref_b_fault;
    end else if (code == OUT_AVALID) begin
      r = st.ref_a_valid;
    end else if (code == OUT_BVALID) begin
      r = st.ref_b_valid;
    end else if (code == OUT_AACT) begin
      r = ~st.ref_b_active;
    end else if (code == OUT_BACT) begin
      r = st.ref_b_active;
    end else if (code == OUT_SYNC) begin
      r = st.sync_pulse;
    end else if (code == OUT_SOFT) begin
      r = st.soft_cfg;
    end
    // Static low and every reserved code fall through to zero
    return r;
  endfunction

  function automatic control_type in_action(input logic [7:0] code);
    control_type c;
    c = '0;
    case (code)
      IN_IOUPD: c.io_update = 1'b1;
      IN_PDOWN: c.power_down = 1'b1;
      IN_WDCLR: c.wd_clear = 1'b1;
      IN_IRQCLR: c.clear_irqs = 1'b1;
      IN_HRST: c.hist_reset = 1'b1;
      IN_HOLD: c.user_holdover = 1'b1;
      IN_FREE: c.user_freerun = 1'b1;
      IN_PRST: c.phase_reset = 1'b1;
      IN_PINC: c.phase_inc = 1'b1;
      IN_PDEC: c.phase_dec = 1'b1;
      IN_OVRA: c.override_a = 1'b1;
      IN_OVRB: c.override_b = 1'b1;
      IN_VTOA: c.force_to_a = 1'b1;
      IN_VTOB: c.force_to_b = 1'b1;
      IN_EN0: c.clock_output_zero_enable = 1'b1;
      IN_EN1: c.clock_output_one_enable = 1'b1;
      IN_ENB: begin
        c.clock_output_zero_enable = 1'b1;
        c.clock_output_one_enable = 1'b1;
      end
      IN_SYNC: c.sync_outputs = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction

  // Wishbone ack
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= CYC_I & STB_I & ~ACK_O;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DAT_O <= '0;
    end else if (req) begin
      DAT_O <= '0;
      if (pin_hit) begin
        DAT_O[7:0] <= pin_code[pin_idx];
      end else if (ADR_I == SEQ_CTRL_ADDR) begin
        DAT_O[SEQ_BUSY_BIT] <= (seq_state == SEQ_RUN);
        DAT_O[SEQ_PTR_LSB +: EE_AW] <= ee_ptr;
      end else if (ADR_I == PIN_LEVEL_ADDR) begin
        DAT_O[NUM_PINS-1:0] <= pin_level;
      end else if (seq_hit) begin
        DAT_O[7:0] <= seq_mem[seq_idx];
      end
    end
  end

  // Pin function codes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_code[i] <= PIN_CODE_RESET;
      end
    end else if (wr && pin_hit) begin
      pin_code[pin_idx] <= DAT_I[7:0];
    end
  end

  // Sequence space; software may append past the end location
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      seq_mem[0] <= END_RESET;
      for (int i = 1; i < SEQ_DEPTH; i++) begin
        seq_mem[i] <= SPARE_RESET;
      end
    end else if (wr && seq_hit) begin
      seq_mem[seq_idx] <= DAT_I[7:0];
    end
  end

  // Storage sequencer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      seq_state <= SEQ_IDLE;
      scan <= '0;
      ee_ptr <= '0;
      EE <= '0;
    end else begin
      EE.valid <= 1'b0;
      case (seq_state)
        SEQ_IDLE: begin
          if (wr && ADR_I == SEQ_CTRL_ADDR && DAT_I[SEQ_START_BIT]) begin
            seq_state <= SEQ_RUN;
            scan <= '0;
          end
        end
        SEQ_RUN: begin
          EE.valid <= 1'b1;
          EE.addr <= ee_ptr;
          EE.data <= instr;
          if (instr == END_CODE) begin
            ee_ptr <= '0;
            seq_state <= SEQ_IDLE;
          end else if (instr == PAUSE_CODE) begin
            ee_ptr <= ee_ptr + 1'b1;
            seq_state <= SEQ_IDLE;
          end else begin
            ee_ptr <= ee_ptr + 1'b1;
            if (scan == SEQ_LAST) begin
              seq_state <= SEQ_IDLE;
            end else begin
              scan <= scan + 1'b1;
            end
          end
        end
        default: seq_state <= SEQ_IDLE;
      endcase
    end
  end

  // Three stage pin synchroniser; level follows once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_level <= '0;
    end else begin
      sync1 <= PIN_I;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
    end
  end

  // Free running divide by 32 of the system clock
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // Input pins only act while bit 7 is low
    assign pin_act[i] = (!pin_code[i][DIR_BIT] && pin_level[i]) ?
                        in_action(pin_code[i]) : '0;

    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        PIN_OE_N[i] <= 1'b1;
        PIN_O[i] <= 1'b0;
      end else begin
        PIN_OE_N[i] <= ~pin_code[i][DIR_BIT];
        PIN_O[i] <= pin_code[i][DIR_BIT] &
                    out_level(pin_code[i], STATUS, div_count[DIV_W-1], WATCHDOG);
      end
    end

    dir_out_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i][DIR_BIT] |=> !PIN_OE_N[i])
      else $error("Output code left pin undriven");
    dir_in_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      !pin_code[i][DIR_BIT] |=> PIN_OE_N[i] && !PIN_O[i])
      else $error("Input code drove the pin");
    div_out_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == OUT_DIV |=> PIN_O[i] == $past(div_count[DIV_W-1]))
      else $error("Divided clock not on pin");
    ee_mirror_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == 8'h85 |=> PIN_O[i] == $past(STATUS.ee[1]))
      else $error("Download busy not mirrored");
    all_lock_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == 8'h8c |=> PIN_O[i] == $past(STATUS.dl_state[4]
        & STATUS.analog_loop_lock & STATUS.pll[0]))
      else $error("All lock output wrong");
    dl_state_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == 8'h92 |=> PIN_O[i] == $past(STATUS.dl_state[2]))
      else $error("Holdover state not mirrored");
    ref_active_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == 8'hc0 |=> PIN_O[i] != $past(STATUS.ref_b_active))
      else $error("Reference A active wrong");
    reserved_out_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == 8'h8e |=> !PIN_O[i] && !PIN_OE_N[i])
      else $error("Reserved output not low");
    io_update_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == IN_IOUPD && pin_level[i] |=> CTRL.io_update)
      else $error("Pin I/O update not applied");
    out_both_a: assert property (
      @(posedge CLK) disable iff (!RST_N)
      pin_code[i] == IN_ENB && pin_level[i] |=> CTRL.clock_output_zero_enable
        && CTRL.clock_output_one_enable)
      else $error("Both outputs not enabled");
  end

  // Pins sharing a function are ORed
  always_comb begin
    next_ctrl = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      next_ctrl = control_type'(next_ctrl | pin_act[i]);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CTRL <= '0;
    end else begin
      CTRL <= next_ctrl;
    end
  end

  end_ptr_zero_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    seq_state == SEQ_RUN && instr == END_CODE |=>
      ee_ptr == '0 && seq_state == SEQ_IDLE && EE.valid && EE.data == END_CODE)
    else $error("End code did not reset pointer");
  pause_ptr_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    seq_state == SEQ_RUN && instr == PAUSE_CODE |=>
      ee_ptr == $past(ee_ptr) + 1'b1 && seq_state == SEQ_IDLE)
    else $error("Pause did not advance pointer");
  spare_run_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    seq_state == SEQ_RUN && instr != END_CODE && instr != PAUSE_CODE
      && scan != SEQ_LAST |=> seq_state == SEQ_RUN && scan == $past(scan) + 1'b1)
    else $error("Sequence stopped early");
  wb_ack_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("Ack not a single cycle");

  end_seen_c: cover property (
    @(posedge CLK) disable iff (!RST_N) seq_state == SEQ_RUN && instr == END_CODE);
  pause_seen_c: cover property (
    @(posedge CLK) disable iff (!RST_N) seq_state == SEQ_RUN && instr == PAUSE_CODE);
  div_pin_c: cover property (
    @(posedge CLK) disable iff (!RST_N) pin_code[1] == OUT_DIV ##1 PIN_O[1]);
  sync_in_c: cover property (
    @(posedge CLK) disable iff (!RST_N) CTRL.sync_outputs);

endmodule

//--- testbench/pin_board_model.sv
// Purpose: Board side of the multifunction pins
// Assumes: Each board line has a pull-down when nobody drives it
// Notes: Board drive and device drive together are counted as contention
module pin_board_model
  import mfp_pkg::*;
(
  // Board stimulus
  input wire logic [NUM_PINS-1:0] drive_en,
  input wire logic [NUM_PINS-1:0] drive_lvl,
  // Device pin side
  input wire logic [NUM_PINS-1:0] pin_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  output logic [NUM_PINS-1:0] pin_wire,
  output logic contention
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    contention = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      // Output pins show the device level, input pins the board level
      if (pin_oe_n[i] === 1'b0) begin
        pin_wire[i] = pin_o[i];
      end else if (drive_en[i]) begin
        pin_wire[i] = drive_lvl[i];
      end else begin
        pin_wire[i] = 1'b0;
      end
      // Flag a fight between board and device
      if (pin_oe_n[i] === 1'b0 && drive_en[i]) begin
        contention = 1'b1;
      end
    end
  end
endmodule

//--- testbench/multifunction_pin_select_tb.sv
// Purpose: Self-checking bench for the multifunction pin select block
// Assumes: Wishbone answers within a bounded wait; pin 1 outputs, pin 2 inputs
// Notes: Input pins need several cycles to pass the synchronizer
module multifunction_pin_select_tb import mfp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic ack;
  logic [3:0] pin_i;
  logic [3:0] pin_o;
  logic [3:0] pin_oe_n;
  logic [3:0] drive_en = 4'h0;
  logic [3:0] drive_lvl = 4'h0;
  logic contention;
  status_type status = '0;
  logic watchdog = 1'b0;
  control_type ctrl;
  ee_write_type ee;
  int checks = 0;
  int miscompares = 0;
  logic [19:0] ee_log[$];
  localparam logic [7:0] IN_LIST [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h14, 8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41, 8'h47};

  always #5 CLK = ~CLK;
  always @(posedge CLK) if (ee.valid === 1'b1) ee_log.push_back({ee.addr, ee.data});

  multifunction_pin_select u_dut (.CLK(CLK), .RST_N(RST_N), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n), .STATUS(status),
    .WATCHDOG(watchdog), .CTRL(ctrl), .EE(ee));

  pin_board_model u_board (.drive_en(drive_en), .drive_lvl(drive_lvl), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .pin_wire(pin_i), .contention(contention));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge CLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) check("ack wait", 32'h1, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic test_reset();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, PIN_CODE_ADDR + 16'(4 * i), 32'h0, q);
      check("pin code reset", q, 32'h00000000);
    end
    wb(1'b0, 16'h38f0, 32'h0, q);
    check("end instruction reset", q, 32'h000000ff);
    wb(1'b0, 16'h38f4, 32'h0, q);
    check("spare reset", q, 32'h00000000);
    wb(1'b1, 16'h0200, 32'h000000a5, q);
    wb(1'b0, 16'h0200, 32'h0, q);
    check("unmapped read", q, 32'h00000000);
    check("oe_n after reset", 32'(pin_oe_n), 32'h0000000f);
    check("ctrl after reset", 32'(ctrl), 32'h00000000);
    $display("test reset done");
  endtask

  // Pin 1 given a code; value with s, then with every status bit inverted
  task automatic out_pin(input logic [7:0] code, input status_type s, input logic e1,
    input logic e2);
    logic [31:0] q;
    wb(1'b1, 16'h0004, {24'h0, code}, q);
    status <= s;
    idle(3);
    check("pin1 oe_n", 32'(pin_oe_n[1]), 32'h0);
    check("pin1 level", 32'(pin_o[1]), 32'(e1));
    status <= ~s;
    idle(3);
    check("pin1 level inverted", 32'(pin_o[1]), 32'(e2));
  endtask

  task automatic test_outputs();
    status_type s;
    logic [31:0] q;
    logic p;
    int t;
    s = '0;
    out_pin(8'h80, s, 1'b0, 1'b0);
    out_pin(8'h81, s, 1'b1, 1'b1);
    out_pin(8'hc0, s, 1'b1, 1'b0);
    out_pin(8'hc1, s, 1'b0, 1'b1);
    out_pin(8'h8e, s, 1'b0, 1'b0);
    out_pin(8'h9a, s, 1'b0, 1'b0);
    out_pin(8'hd2, s, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      s = '0;
      s.ee[i] = 1'b1;
      out_pin(OUT_EE + 8'(i), s, 1'b1, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      s = '0;
      s.pll[i] = 1'b1;
      out_pin(OUT_PLL + 8'(i), s, 1'b1, 1'b0);
    end
    for (int i = 0; i < 7; i++) begin
      s = '0;
      s.dl_state[i] = 1'b1;
      out_pin(OUT_DL + 8'(i), s, 1'b1, 1'b0);
    end
    s = '0;
    s.dl_state[4] = 1'b1;
    s.analog_loop_lock = 1'b1;
    out_pin(8'h8d, s, 1'b1, 1'b0);
    out_pin(8'h8c, s, 1'b0, 1'b0);
    s.pll[0] = 1'b1;
    out_pin(8'h8c, s, 1'b1, 1'b0);
    s = '0;
    s.dl_clamped = 1'b1;
    out_pin(8'h97, s, 1'b1, 1'b0);
    s = '0;
    s.hist_avail = 1'b1;
    out_pin(8'h98, s, 1'b1, 1'b0);
    s = '0;
    s.hist_updated = 1'b1;
    out_pin(8'h99, s, 1'b1, 1'b0);
    s = '0;
    s.ref_a_fault = 1'b1;
    out_pin(8'ha0, s, 1'b1, 1'b0);
    s = '0;
    s.ref_b_fault = 1'b1;
    out_pin(8'ha1, s, 1'b1, 1'b0);
    s = '0;
    s.ref_a_valid = 1'b1;
    out_pin(8'hb0, s, 1'b1, 1'b0);
    s = '0;
    s.ref_b_valid = 1'b1;
    out_pin(8'hb1, s, 1'b1, 1'b0);
    s = '0;
    s.sync_pulse = 1'b1;
    out_pin(8'hd0, s, 1'b1, 1'b0);
    s = '0;
    s.soft_cfg = 1'b1;
    out_pin(8'hd1, s, 1'b1, 1'b0);
    // Clock over 32 toggles every 16 cycles
    wb(1'b1, 16'h0004, 32'h00000082, q);
    idle(4);
    t = 0;
    p = pin_o[1];
    repeat (64) begin
      @(posedge CLK);
      if (pin_o[1] !== p) t++;
      p = pin_o[1];
    end
    check("divided clock edges", 32'(t), 32'h4);
    wb(1'b1, 16'h0004, 32'h00000083, q);
    watchdog <= 1'b1;
    idle(3);
    check("watchdog high", 32'(pin_o[1]), 32'h1);
    watchdog <= 1'b0;
    idle(3);
    check("watchdog low", 32'(pin_o[1]), 32'h0);
    wb(1'b1, 16'h0004, 32'h00000000, q);
    idle(3);
    check("pin1 back to input", 32'(pin_oe_n[1]), 32'h1);
    $display("test outputs done");
  endtask

  // Pin 2 driven by the board high, then low
  task automatic in_case(input logic [7:0] code, input logic [16:0] exp);
    logic [31:0] q;
    wb(1'b1, 16'h0008, {24'h0, code}, q);
    drive_en[2] <= 1'b1;
    drive_lvl[2] <= 1'b1;
    idle(6);
    check("ctrl pin high", 32'(ctrl), 32'(exp));
    check("pin2 oe_n", 32'(pin_oe_n[2]), 32'h1);
    check("board contention", 32'(contention), 32'h0);
    wb(1'b0, PIN_LEVEL_ADDR, 32'h0, q);
    check("pin level readback", q & 32'h4, 32'h4);
    drive_lvl[2] <= 1'b0;
    idle(6);
    check("ctrl pin low", 32'(ctrl), 32'h0);
  endtask

  task automatic test_inputs();
    for (int i = 0; i < 17; i++) begin
      in_case(IN_LIST[i], 17'h10000 >> i);
    end
    in_case(8'h46, 17'h00006);
    in_case(8'h00, 17'h00000);
    in_case(8'h06, 17'h00000);
    in_case(8'h48, 17'h00000);
    $display("test inputs done");
  endtask

  task automatic run_seq(output logic [31:0] q);
    int n;
    ee_log.delete();
    wb(1'b1, SEQ_CTRL_ADDR, 32'h1, q);
    n = 0;
    do begin
      wb(1'b0, SEQ_CTRL_ADDR, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
  endtask

  task automatic seq_pair(input logic [11:0] a, input logic [7:0] d, input logic [11:0] ptr);
    logic [31:0] q;
    run_seq(q);
    check("store count", 32'(ee_log.size()), 32'h2);
    check("first store", 32'(ee_log[0]), {12'h0, a, 8'h12});
    check("last store", 32'(ee_log[1]), {12'h0, a + 12'h1, d});
    check("pointer", 32'(q[27:16]), 32'(ptr));
  endtask

  task automatic test_sequence();
    logic [31:0] q;
    run_seq(q);
    check("end only count", 32'(ee_log.size()), 32'h1);
    check("end only store", 32'(ee_log[0]), 32'h000000ff);
    check("end only pointer", 32'(q[27:16]), 32'h0);
    wb(1'b1, 16'h38f0, 32'h00000012, q);
    wb(1'b1, 16'h38f4, 32'h000000fe, q);
    wb(1'b0, 16'h38f4, 32'h0, q);
    check("spare readback", q, 32'h000000fe);
    seq_pair(12'h000, 8'hfe, 12'h002);
    seq_pair(12'h002, 8'hfe, 12'h004);
    wb(1'b1, 16'h38f4, 32'h000000ff, q);
    seq_pair(12'h004, 8'hff, 12'h000);
    $display("test sequence done");
  endtask

  // Whole run is under a thousand cycles; this limit leaves ample margin
  initial begin
    #200000;
    miscompares++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    test_reset();
    test_outputs();
    test_inputs();
    test_sequence();
    end_sim();
  end
endmodule
